// ### hdl/pio_top.sv
// Purpose: Parallel I/O ports, pin controls, ganged output and pin interrupts behind APB
// Assumes: Pin inputs are asynchronous; peripheral and analog enables come from i_clk logic
// Notes:   APB slave answers with no wait state; unmapped addresses give pslverr
// Notes on behaviour
// - An enabled shared peripheral takes the pin away from general-purpose I/O.
// - Reset clears directions, slew, drive and pull bits; peripherals disabled.
// - Direction bit enables output buffer and picks data read source.
// - Data read gives pin level for inputs, latch value for outputs.
// - Input buffer always on except analog pins and the output-only pin.
// - Peripheral controls output buffer; direction bit still picks read source.
// - Analog disables both buffers; input read with buffer off gives zero.
// - Analog function wins over digital alternate function on a pin.
// - Pull enabled by its bit, forced off for outputs and analog pins.
// - Per-pin slew control, meaningless while pin is input.
// - Per-pin drive select picks high drive when set.
// - Gang control takes only first write; enable bit plus select bits 7:1.
// - Ganged pins become outputs following master pin data, drive and slew.
// - Select bits 7..1 map to B5,B4,B3,B2,C3,C2,C1; enable maps to C0.
// - Ganged output beats peripherals; analog beats ganged output.
// - Gang enable forces master pin to output regardless of its direction.
// - Pins A3:0 and B3:0 serve as interrupt and wake inputs.
// - Per-pin enable and polarity; per-port edge or edge-and-level mode.
// - Edge seen as deasserted then asserted on consecutive bus clocks.
// - An input must be seen deasserted before an edge counts.
// - Edge sets flag, unmask raises request, acknowledge one clears flag.
// - Level mode: acknowledge clears only when all enabled inputs deasserted.
`timescale 1ns/1ps
`include "pio_consts.svh"
module pio_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic              i_clk,
	input  wire logic              i_rstn,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic [31:0]            o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	input  wire pio_pkg::pio_pins_t i_pin_in,
	output pio_pkg::pio_pins_t     o_pin_out,
	output pio_pkg::pio_pins_t     o_pin_oe_n,
	output pio_pkg::pio_pins_t     o_pin_ibuf_en,
	output pio_pkg::pio_pins_t     o_pin_pull_en,
	output pio_pkg::pio_pins_t     o_pin_slew,
	output pio_pkg::pio_pins_t     o_pin_drive_hi,
	input  wire pio_pkg::pio_pins_t i_per_en,
	input  wire pio_pkg::pio_pins_t i_per_oe,
	input  wire pio_pkg::pio_pins_t i_per_out,
	input  wire pio_pkg::pio_pins_t i_ana_en,
	output pio_pkg::pio_pins_t     o_per_in,
	output logic                   o_irq_a,
	output logic                   o_irq_b,
	output logic                   o_wake
);
	if (ADDR_W < 8) begin : g_chk
		$error("pio_top: ADDR_W must be at least 8");
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic int unsigned port_lo(input logic [1:0] p);
		return (p == 2'h0) ? `PIO_A_LO : (p == 2'h1) ? `PIO_B_LO : `PIO_C_LO;
	endfunction

	function automatic pio_pkg::pio_pins_t port_mask(input logic [1:0] p);
		pio_pkg::pio_pins_t m;
		m = '0;
		for (int i = 0; i < `PIO_NPINS; i++) begin
			if (p == 2'h0) m[i] = (i < `PIO_B_LO);
			else if (p == 2'h1) m[i] = (i >= `PIO_B_LO) && (i < `PIO_C_LO);
			else m[i] = (i >= `PIO_C_LO);
		end
		return m;
	endfunction

	// Merge a written byte into one port's slice of a flat pin vector
	function automatic pio_pkg::pio_pins_t wr_port(input pio_pkg::pio_pins_t old,
			input logic [1:0] p, input logic [7:0] wd);
		pio_pkg::pio_pins_t m;
		pio_pkg::pio_pins_t v;
		m = port_mask(p);
		v = pio_pkg::pio_pins_t'({10'h000, wd} << port_lo(p));
		return (old & ~m) | (v & m);
	endfunction

	// Extract one port's slice, upper bits zero
	function automatic logic [7:0] rd_port(input pio_pkg::pio_pins_t v, input logic [1:0] p);
		pio_pkg::pio_pins_t s;
		s = (v & port_mask(p)) >> port_lo(p);
		return s[7:0];
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	pio_pkg::pio_pins_t data_reg, dir_reg, pull_reg, slew_reg, drive_reg;
	pio_pkg::pio_pins_t sync1_reg, sync2_reg;
	pio_pkg::pio_pins_t out_reg, oen_reg, ibuf_reg, pullo_reg, slewo_reg, drvo_reg, perin_reg;
	pio_pkg::pio_pins_t gang_pin, per_own, drv_en, out_next, ibuf_next, rd_src;
	logic [7:0]         gang_reg;
	logic               gang_done_reg;
	logic [3:0]         ien_a_reg, ien_b_reg, pol_a_reg, pol_b_reg;
	logic               mode_a_reg, mode_b_reg, unm_a_reg, unm_b_reg;
	logic               ack_a, ack_b, flag_a, flag_b;
	logic [31:0]        prdata_reg, rd_next;
	logic               err_reg, hit_next;
	logic               wr_en, setup;
	logic [1:0]         wport;
	logic               is_port, is_irq, is_gang, irq_sel;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Address windows: ports at 0x00/0x20/0x40, interrupt ports 0x60/0x70, gang 0x80
	assign setup   = i_psel & ~i_penable;
	assign wr_en   = i_psel & i_penable & i_pwrite;
	assign wport   = i_paddr[6:5];
	assign is_port = (i_paddr[ADDR_W-1:7] == '0) && (wport != 2'h3) && (i_paddr[4:0] <= `PIO_OFF_DRIVE)
		&& (i_paddr[1:0] == 2'h0);
	assign is_irq  = (i_paddr[ADDR_W-1:5] == (ADDR_W-5)'(3)) && (i_paddr[3:0] <= `PIO_OFF_POL)
		&& (i_paddr[1:0] == 2'h0);
	assign irq_sel = i_paddr[4];
	assign is_gang = (i_paddr == ADDR_W'(`PIO_OFF_GANG));
	assign ack_a   = wr_en & is_irq & ~irq_sel & (i_paddr[3:0] == `PIO_OFF_SC) & i_pwdata[`PIO_SC_ACK];
	assign ack_b   = wr_en & is_irq & irq_sel & (i_paddr[3:0] == `PIO_OFF_SC) & i_pwdata[`PIO_SC_ACK];

	// ----------------------------------------------------------------
	// Pin control registers
	// ----------------------------------------------------------------
	// Port latch, direction and pad controls; all cleared at reset
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			data_reg  <= `PIO_RST_CTRL;
			dir_reg   <= `PIO_RST_CTRL;
			pull_reg  <= `PIO_RST_CTRL;
			slew_reg  <= `PIO_RST_CTRL;
			drive_reg <= `PIO_RST_CTRL;
		end else if (wr_en && is_port) begin
			unique case (i_paddr[4:0])
				`PIO_OFF_DATA:  data_reg  <= wr_port(data_reg, wport, i_pwdata[7:0]);
				`PIO_OFF_DIR:   dir_reg   <= wr_port(dir_reg, wport, i_pwdata[7:0]);
				`PIO_OFF_PULL:  pull_reg  <= wr_port(pull_reg, wport, i_pwdata[7:0]);
				`PIO_OFF_SLEW:  slew_reg  <= wr_port(slew_reg, wport, i_pwdata[7:0]);
				`PIO_OFF_DRIVE: drive_reg <= wr_port(drive_reg, wport, i_pwdata[7:0]);
				default: ;
			endcase
		end
	end

	// Gang control is write-once: the first write after reset locks it
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			gang_reg      <= `PIO_RST_GANG;
			gang_done_reg <= 1'b0;
		end else if (wr_en && is_gang && !gang_done_reg) begin
			gang_reg      <= i_pwdata[7:0];
			gang_done_reg <= 1'b1;
		end
	end

	// Interrupt configuration; the acknowledge bit is a pulse and is not stored
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			ien_a_reg  <= `PIO_RST_IRQ;
			ien_b_reg  <= `PIO_RST_IRQ;
			pol_a_reg  <= `PIO_RST_IRQ;
			pol_b_reg  <= `PIO_RST_IRQ;
			mode_a_reg <= 1'b0;
			mode_b_reg <= 1'b0;
			unm_a_reg  <= 1'b0;
			unm_b_reg  <= 1'b0;
		end else if (wr_en && is_irq) begin
			unique case ({irq_sel, i_paddr[3:0]})
				{1'b0, `PIO_OFF_SC}: begin
					mode_a_reg <= i_pwdata[`PIO_SC_MODE];
					unm_a_reg  <= i_pwdata[`PIO_SC_UNMASK];
				end
				{1'b1, `PIO_OFF_SC}: begin
					mode_b_reg <= i_pwdata[`PIO_SC_MODE];
					unm_b_reg  <= i_pwdata[`PIO_SC_UNMASK];
				end
				{1'b0, `PIO_OFF_IEN}: ien_a_reg <= i_pwdata[3:0];
				{1'b1, `PIO_OFF_IEN}: ien_b_reg <= i_pwdata[3:0];
				{1'b0, `PIO_OFF_POL}: pol_a_reg <= i_pwdata[3:0];
				{1'b1, `PIO_OFF_POL}: pol_b_reg <= i_pwdata[3:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin priority: analog, then gang, then peripheral, then port
	// ----------------------------------------------------------------
	// Gang pins are only forced while the enable bit is set
	always_comb begin
		gang_pin = '0;
		if (gang_reg[0]) begin
			gang_pin[`PIO_GANG_MASTER] = 1'b1;
			gang_pin[`PIO_GANG_SEL1]   = gang_reg[1];
			gang_pin[`PIO_GANG_SEL2]   = gang_reg[2];
			gang_pin[`PIO_GANG_SEL3]   = gang_reg[3];
			gang_pin[`PIO_GANG_SEL4]   = gang_reg[4];
			gang_pin[`PIO_GANG_SEL5]   = gang_reg[5];
			gang_pin[`PIO_GANG_SEL6]   = gang_reg[6];
			gang_pin[`PIO_GANG_SEL7]   = gang_reg[7];
		end
	end

	// Per-pin steering; the peripheral loses to gang and both lose to analog
	always_comb begin
		per_own   = i_per_en & ~gang_pin & ~i_ana_en;
		ibuf_next = ~i_ana_en;
		ibuf_next[`PIO_OUT_ONLY_PIN] = 1'b0;
		for (int i = 0; i < `PIO_NPINS; i++) begin
			if (i_ana_en[i]) begin
				drv_en[i]   = 1'b0;
				out_next[i] = 1'b0;
			end else if (gang_pin[i]) begin
				drv_en[i]   = 1'b1;
				out_next[i] = data_reg[`PIO_GANG_MASTER];
			end else if (per_own[i]) begin
				drv_en[i]   = i_per_oe[i];
				out_next[i] = i_per_out[i];
			end else begin
				drv_en[i]   = dir_reg[i];
				out_next[i] = data_reg[i];
			end
		end
	end

	// Registered pad drive; one cycle of latency traded for glitch-free pads
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			out_reg   <= `PIO_RST_CTRL;
			oen_reg   <= `PIO_RST_OEN;
			ibuf_reg  <= `PIO_RST_IBUF;
			pullo_reg <= `PIO_RST_CTRL;
			slewo_reg <= `PIO_RST_CTRL;
			drvo_reg  <= `PIO_RST_CTRL;
		end else begin
			out_reg   <= out_next;
			oen_reg   <= ~drv_en;
			ibuf_reg  <= ibuf_next;
			pullo_reg <= pull_reg & ~drv_en & ~i_ana_en;
			for (int i = 0; i < `PIO_NPINS; i++) begin
				slewo_reg[i] <= gang_pin[i] ? slew_reg[`PIO_GANG_MASTER] : slew_reg[i];
				drvo_reg[i]  <= gang_pin[i] ? drive_reg[`PIO_GANG_MASTER] : drive_reg[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Input path
	// ----------------------------------------------------------------
	// Two-flop synchroniser; only the second stage is read
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			sync1_reg <= `PIO_RST_CTRL;
			sync2_reg <= `PIO_RST_CTRL;
		end else begin
			sync1_reg <= i_pin_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Level seen by peripherals, zero when the input buffer is off
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			perin_reg <= `PIO_RST_CTRL;
		end else begin
			perin_reg <= sync2_reg & ibuf_next;
		end
	end

	// Read source: latch for outputs and the output-only pin, gated pin for inputs
	always_comb begin
		for (int i = 0; i < `PIO_NPINS; i++) begin
			if (dir_reg[i] || (i == `PIO_OUT_ONLY_PIN)) begin
				rd_src[i] = data_reg[i];
			end else begin
				rd_src[i] = sync2_reg[i] & ibuf_next[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin interrupts on A3:0 and B3:0
	// ----------------------------------------------------------------
	pio_irq_port #(.IRQ_PINS(`PIO_IRQ_W)) u_irq_a (
		.i_clk      (i_clk),
		.i_rstn     (i_rstn),
		.i_pin      (sync2_reg[`PIO_A_LO +: `PIO_IRQ_W]),
		.i_enable   (ien_a_reg),
		.i_polarity (pol_a_reg),
		.i_mode     (mode_a_reg),
		.i_unmask   (unm_a_reg),
		.i_ack      (ack_a),
		.o_flag     (flag_a),
		.o_irq      (o_irq_a)
	);

	pio_irq_port #(.IRQ_PINS(`PIO_IRQ_W)) u_irq_b (
		.i_clk      (i_clk),
		.i_rstn     (i_rstn),
		.i_pin      (sync2_reg[`PIO_B_LO +: `PIO_IRQ_W]),
		.i_enable   (ien_b_reg),
		.i_polarity (pol_b_reg),
		.i_mode     (mode_b_reg),
		.i_unmask   (unm_b_reg),
		.i_ack      (ack_b),
		.o_flag     (flag_b),
		.o_irq      (o_irq_b)
	);

	// Wake follows an unmasked request from either port
	assign o_wake = o_irq_a | o_irq_b;

	// ----------------------------------------------------------------
	// APB read and answer
	// ----------------------------------------------------------------
	// Read mux; data captured in the setup cycle, so it is one cycle old at access
	always_comb begin
		rd_next  = 32'h0000_0000;
		hit_next = is_port | is_irq | is_gang;
		if (is_port) begin
			unique case (i_paddr[4:0])
				`PIO_OFF_DATA:  rd_next[7:0] = rd_port(rd_src, wport);
				`PIO_OFF_DIR:   rd_next[7:0] = rd_port(dir_reg, wport);
				`PIO_OFF_PULL:  rd_next[7:0] = rd_port(pull_reg, wport);
				`PIO_OFF_SLEW:  rd_next[7:0] = rd_port(slew_reg, wport);
				`PIO_OFF_DRIVE: rd_next[7:0] = rd_port(drive_reg, wport);
				default:        hit_next     = 1'b0;
			endcase
		end else if (is_irq) begin
			unique case (i_paddr[3:0])
				`PIO_OFF_SC: begin
					rd_next[`PIO_SC_FLAG]   = irq_sel ? flag_b : flag_a;
					rd_next[`PIO_SC_UNMASK] = irq_sel ? unm_b_reg : unm_a_reg;
					rd_next[`PIO_SC_MODE]   = irq_sel ? mode_b_reg : mode_a_reg;
				end
				`PIO_OFF_IEN: rd_next[3:0] = irq_sel ? ien_b_reg : ien_a_reg;
				`PIO_OFF_POL: rd_next[3:0] = irq_sel ? pol_b_reg : pol_a_reg;
				default:      hit_next     = 1'b0;
			endcase
		end else if (is_gang) begin
			rd_next[7:0] = gang_reg;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			prdata_reg <= 32'h0000_0000;
			err_reg    <= 1'b0;
		end else if (setup) begin
			prdata_reg <= i_pwrite ? 32'h0000_0000 : rd_next;
			err_reg    <= ~hit_next;
		end
	end

	assign o_prdata       = prdata_reg;
	assign o_pready       = 1'b1;
	assign o_pslverr      = i_psel & i_penable & err_reg;
	assign o_pin_out      = out_reg;
	assign o_pin_oe_n     = oen_reg;
	assign o_pin_ibuf_en  = ibuf_reg;
	assign o_pin_pull_en  = pullo_reg;
	assign o_pin_slew     = slewo_reg;
	assign o_pin_drive_hi = drvo_reg;
	assign o_per_in       = perin_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_RESET_CLEARS: assert property (@(posedge i_clk)
		!i_rstn |=> (dir_reg == '0) && (pull_reg == '0) && (slew_reg == '0) && (drive_reg == '0)
		&& (gang_reg == '0)) else $error("reset left control bits set");
	AST_ANALOG_BUFFERS_OFF: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$past(i_rstn) |-> &(o_pin_oe_n | ~$past(i_ana_en)) && ((o_pin_ibuf_en & $past(i_ana_en)) == '0))
		else $error("analog pin buffer enabled");
	AST_PULL_OFF_DRIVING: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(o_pin_pull_en & ~o_pin_oe_n) == '0) else $error("pull on while driving");
	AST_GANG_LOCKED: assert property (@(posedge i_clk) disable iff (!i_rstn)
		gang_done_reg |=> $stable(gang_reg)) else $error("gang control changed after first write");
	AST_MASTER_FORCED: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(gang_reg[0] && !i_ana_en[`PIO_GANG_MASTER]) |=> !o_pin_oe_n[`PIO_GANG_MASTER])
		else $error("gang master not driven");
endmodule // pio_top

// ### hdl/pio_consts.svh
// Purpose: Offsets, field positions, reset values and pin map of the parallel I/O block
// Assumes: Included by bare name after the package
// Notes:   Pins are one flat vector: port A 0..5, port B 6..13, port C 14..17
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH

// ----------------------------------------------------------------
// Pin layout
// ----------------------------------------------------------------
`define PIO_NPINS        18
`define PIO_A_LO         0
`define PIO_A_W          6
`define PIO_B_LO         6
`define PIO_B_W          8
`define PIO_C_LO         14
`define PIO_C_W          4
`define PIO_IRQ_W        4
`define PIO_OUT_ONLY_PIN 4
`define PIO_GANG_MASTER  14
`define PIO_GANG_SEL1    15
`define PIO_GANG_SEL2    16
`define PIO_GANG_SEL3    17
`define PIO_GANG_SEL4    8
`define PIO_GANG_SEL5    9
`define PIO_GANG_SEL6    10
`define PIO_GANG_SEL7    11

// ----------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------
`define PIO_BASE_A    8'h00
`define PIO_BASE_B    8'h20
`define PIO_BASE_C    8'h40
`define PIO_OFF_DATA  5'h00
`define PIO_OFF_DIR   5'h04
`define PIO_OFF_PULL  5'h08
`define PIO_OFF_SLEW  5'h0c
`define PIO_OFF_DRIVE 5'h10
`define PIO_BASE_IRQA 8'h60
`define PIO_BASE_IRQB 8'h70
`define PIO_OFF_SC    4'h0
`define PIO_OFF_IEN   4'h4
`define PIO_OFF_POL   4'h8
`define PIO_OFF_GANG  8'h80

// ----------------------------------------------------------------
// Status and control fields, reset values
// ----------------------------------------------------------------
`define PIO_SC_MODE   0
`define PIO_SC_UNMASK 1
`define PIO_SC_ACK    2
`define PIO_SC_FLAG   3
`define PIO_RST_CTRL  18'h0_0000
`define PIO_RST_OEN   18'h3_ffff
`define PIO_RST_IBUF  18'h3_ffef
`define PIO_RST_GANG  8'h00
`define PIO_RST_IRQ   4'h0

`endif

// ### hdl/pio_pkg.sv
// Purpose: Shared types of the parallel I/O block
// Assumes: Nothing
// Notes:   Constants live in pio_consts.svh
package pio_pkg;
	typedef logic [17:0] pio_pins_t;
	typedef enum logic [1:0] {PIO_PORT_A, PIO_PORT_B, PIO_PORT_C} pio_port_e;
endpackage

// ### hdl/pio_irq_port.sv
// Purpose: Pin interrupt detection for one port
// Assumes: i_pin is already synchronised to i_clk
// Notes:   Flag set wins over an acknowledge in the same cycle
`timescale 1ns/1ps
module pio_irq_port #(
	parameter int IRQ_PINS = 4
) (
	input  wire logic                i_clk,
	input  wire logic                i_rstn,
	input  wire logic [IRQ_PINS-1:0] i_pin,
	input  wire logic [IRQ_PINS-1:0] i_enable,
	input  wire logic [IRQ_PINS-1:0] i_polarity,
	input  wire logic                i_mode,
	input  wire logic                i_unmask,
	input  wire logic                i_ack,
	output logic                     o_flag,
	output logic                     o_irq
);
	logic [IRQ_PINS-1:0] act;
	logic [IRQ_PINS-1:0] armed_reg;
	logic [IRQ_PINS-1:0] edge_hit;
	logic                any_act;
	logic                set_ev;
	logic                flag_reg;

	if (IRQ_PINS < 1 || IRQ_PINS > 8) begin : g_chk
		$error("pio_irq_port: IRQ_PINS must be 1 to 8");
	end

	// Asserted level: polarity 1 means high, 0 means low
	assign act      = ~(i_pin ^ i_polarity);
	assign edge_hit = i_enable & act & armed_reg;
	assign any_act  = |(i_enable & act);
	assign set_ev   = (|edge_hit) | (i_mode & any_act);

	// Armed once an enabled input was seen deasserted the cycle before
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			armed_reg <= '0;
		end else begin
			armed_reg <= i_enable & ~act;
		end
	end

	// Flag: set beats acknowledge; level mode holds while any input is active
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			flag_reg <= 1'b0;
		end else if (set_ev) begin
			flag_reg <= 1'b1;
		end else if (i_ack && (!i_mode || !any_act)) begin
			flag_reg <= 1'b0;
		end
	end

	assign o_flag = flag_reg;
	assign o_irq  = flag_reg & i_unmask;

	AST_EDGE_SETS_FLAG: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(|edge_hit) |=> o_flag) else $error("edge did not set flag");
	AST_ACK_CLEARS_EDGE: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_ack && !i_mode && !set_ev) |=> !o_flag) else $error("ack did not clear flag");
	AST_LEVEL_HOLDS: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_mode && any_act) |=> o_flag) else $error("active level did not hold flag");
	AST_NO_EDGE_UNARMED: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(!i_mode && !o_flag && $stable(i_enable) && ($past(i_enable) & ~$past(act)) == '0) |=> !o_flag)
		else $error("flag set without prior deasserted level");
endmodule // pio_irq_port

// ### dv/pio_pin_model.sv
// Purpose: Pads and outside world seen by the parallel I/O block
// Assumes: Bench chooses which pads an outside source drives
// Notes:   Pull is modelled as pull-up; a floating pad flips each clock
`timescale 1ns/1ps
module pio_pin_model (
	input  wire logic               i_clk,
	input  wire pio_pkg::pio_pins_t i_out,
	input  wire pio_pkg::pio_pins_t i_oe_n,
	input  wire pio_pkg::pio_pins_t i_pull,
	input  wire pio_pkg::pio_pins_t i_ext_val,
	input  wire pio_pkg::pio_pins_t i_ext_en,
	output pio_pkg::pio_pins_t      o_level
);
	// ----------------------------------------------------------------
	// Pad level
	// ----------------------------------------------------------------
	// A floating pad must not hold its last value, so it toggles
	pio_pkg::pio_pins_t level_reg = '0;
	always @(posedge i_clk) begin
		for (int i = 0; i < 18; i++) begin
			if (!i_oe_n[i]) level_reg[i] <= i_out[i];
			else if (i_ext_en[i]) level_reg[i] <= i_ext_val[i];
			else if (i_pull[i]) level_reg[i] <= 1'b1;
			else level_reg[i] <= ~level_reg[i];
		end
	end
	assign o_level = level_reg;
endmodule // pio_pin_model

// ### dv/pio_top_tb.sv
// Purpose: Self-checking bench of the parallel I/O block over APB
// Assumes: Zero-wait APB slave, pads behind a pin model
// Notes:   Gang control is write-once, so it is tested last
`timescale 1ns/1ps
module pio_top_tb;
	logic               clk, rstn, psel, penable, pwrite, pready, pslverr, irq_a, irq_b, wake, err;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rd;
	pio_pkg::pio_pins_t pin_in, out, oe_n, ibuf, pull, slew, drv, per_in;
	pio_pkg::pio_pins_t per_en, per_oe, per_out, ana_en, ext_val, ext_en;
	int                 mismatches = 0;
	int                 tests_run = 0;

	pio_top DUT (.i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_pin_in(pin_in), .o_pin_out(out), .o_pin_oe_n(oe_n), .o_pin_ibuf_en(ibuf), .o_pin_pull_en(pull),
		.o_pin_slew(slew), .o_pin_drive_hi(drv), .i_per_en(per_en), .i_per_oe(per_oe), .i_per_out(per_out),
		.i_ana_en(ana_en), .o_per_in(per_in), .o_irq_a(irq_a), .o_irq_b(irq_b), .o_wake(wake));
	pio_pin_model PADS (.i_clk(clk), .i_out(out), .i_oe_n(oe_n), .i_pull(pull), .i_ext_val(ext_val),
		.i_ext_en(ext_en), .o_level(pin_in));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("compares %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Request held until the edge at which pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			mismatches++;
			tally_and_finish();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string what);
		apb(1'b0, a, 32'h0);
		chk(rd, e, what);
	endtask
	// Covers two sync flops, the pad model and register latency
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask

	// ----------------------------------------------------------------
	// Clock and sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		{rstn, psel, penable, pwrite, paddr, pwdata} = '0;
		{per_en, per_oe, per_out, ana_en} = '0;
		ext_en = 18'h3_ffe1;
		ext_val = 18'h0_0020;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		settle();
		chk(oe_n, 32'h3_ffff, "oe after reset");
		chk(ibuf, 32'h3_ffef, "ibuf after reset");
		chk(pull | slew | drv, 32'h0, "pad controls after reset");
		rdc(8'h04, 32'h0, "dir A after reset");
		$display("test reset done");
		wr(8'h00, 32'h05);
		wr(8'h04, 32'h1f);
		wr(8'h08, 32'h3f);
		wr(8'h0c, 32'h3f);
		settle();
		chk(oe_n[5:0], 32'h20, "A output enables");
		chk(out[3:0], 32'h5, "A pad values");
		chk(pull[5:0], 32'h20, "A pulls off on outputs");
		chk(slew[4:0], 32'h1f, "A slew on outputs");
		rdc(8'h00, 32'h25, "A mixed read");
		$display("test port A done");
		@(posedge clk);
		{per_en[6], per_oe[6], per_out[6]} <= 3'b111;
		wr(8'h28, 32'h1);
		settle();
		chk({oe_n[6], out[6], pull[6]}, 32'h2, "peripheral owns pad");
		rdc(8'h20, 32'h1, "B read follows pad");
		chk(per_in[6], 32'h1, "peripheral sees pad");
		@(posedge clk);
		ana_en[6] <= 1'b1;
		ext_val[6] <= 1'b1;
		settle();
		chk({oe_n[6], ibuf[6]}, 32'h2, "analog frees pad");
		chk(per_in[6], 32'h0, "analog gates peripheral input");
		rdc(8'h20, 32'h0, "analog input reads zero");
		$display("test peripheral done");
		wr(8'h70, 32'h0);
		wr(8'h78, 32'h2);
		wr(8'h74, 32'h2);
		wr(8'h70, 32'h4);
		wr(8'h70, 32'h2);
		settle();
		chk(irq_b, 32'h0, "no false flag");
		@(posedge clk);
		ext_val[7] <= 1'b1;
		settle();
		chk({irq_b, wake, irq_a}, 32'h6, "rising edge raises");
		rdc(8'h70, 32'ha, "flag in status");
		wr(8'h70, 32'h6);
		settle();
		chk(irq_b, 32'h0, "edge ack clears");
		wr(8'h70, 32'h3);
		settle();
		chk(irq_b, 32'h1, "high level sets");
		wr(8'h70, 32'h7);
		settle();
		chk(irq_b, 32'h1, "ack refused while high");
		@(posedge clk);
		ext_val[7] <= 1'b0;
		settle();
		chk(irq_b, 32'h1, "level flag sticks until ack");
		wr(8'h70, 32'h7);
		settle();
		chk(irq_b, 32'h0, "ack clears when idle");
		wr(8'h64, 32'h1);
		wr(8'h60, 32'h6);
		wr(8'h00, 32'h04);
		settle();
		chk(irq_a, 32'h1, "falling edge raises A");
		$display("test pin interrupt done");
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped read errors");
		chk(rd, 32'h0, "unmapped read is zero");
		wr(8'h40, 32'h1);
		wr(8'h50, 32'h1);
		wr(8'h80, 32'h81);
		wr(8'h80, 32'h0);
		@(posedge clk);
		{per_en[11], per_oe[11], per_out[11]} <= 3'b110;
		settle();
		rdc(8'h80, 32'h81, "gang control locked");
		chk({oe_n[14], oe_n[11], oe_n[8], out[11], drv[11]}, 32'h7, "ganged pad");
		@(posedge clk);
		ana_en[11] <= 1'b1;
		settle();
		chk(oe_n[11], 32'h1, "analog beats gang");
		$display("test gang done");
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		settle();
		chk(oe_n[14], 32'h1, "master released by reset");
		rdc(8'h80, 32'h0, "gang cleared by reset");
		wr(8'h80, 32'h1);
		rdc(8'h80, 32'h1, "gang writable after reset");
		$display("test second reset done");
		tally_and_finish();
	end
endmodule // pio_top_tb
